// [pkg/dsmd_consts.vh]
// Operation codes, field positions and constants of the signed multiply datapath.
`ifndef DSMD_CONSTS_VH
`define DSMD_CONSTS_VH

// ------------------------------------------------------------
// Operation codes
// ------------------------------------------------------------
`define DSMD_OP_W 3
`define DSMD_OP_DUAL_MUL_SUB_ACC 3'h0
`define DSMD_OP_DUAL_MUL_SUB_ACC_LONG 3'h1
`define DSMD_OP_MSW_MUL_ACC 3'h2
`define DSMD_OP_MSW_MUL_SUB 3'h3
`define DSMD_OP_MSW_MUL 3'h4
`define DSMD_OP_DUAL_MUL_ADD 3'h5
`define DSMD_OP_DUAL_MUL_DIFF 3'h6
`define DSMD_OP_LONG_HALFWORD_MUL_ACC 3'h7

// ------------------------------------------------------------
// Status word fields and constants
// ------------------------------------------------------------
`define DSMD_PSW_N 31
`define DSMD_PSW_Z 30
`define DSMD_PSW_C 29
`define DSMD_PSW_V 28
`define DSMD_PSW_Q 27
`define DSMD_PSW_RESET 32'h00000000
`define DSMD_ROUND_CONST 64'h0000000080000000
`define DSMD_HALF_LO 15:0
`define DSMD_HALF_HI 31:16

`endif

// [rtl/dsmd_half_mul.v]
// Signed 16 by 16 bit halfword multiplier.
`timescale 1ns/1ps
module dsmd_half_mul (
    a,
    b,
    p
);
    input wire [15:0] a;
    input wire [15:0] b;
    output wire [31:0] p;

    assign p = $signed(a) * $signed(b);
endmodule

// [rtl/dsmd_datapath.v]
// Signed DSP multiply datapath with registered results and sticky saturation flag.
`timescale 1ns/1ps
`include "dsmd_consts.vh"

// Overview of operation
// (RULE1) Dual halfword products: low minus high plus accumulate.
// (RULE2) Exchange swaps second operand halfwords.
// (RULE3) Long form adds difference to 64-bit pair.
// (RULE4) Accumulate overflow sets sticky flag only.
// (RULE5) Condition flags kept on dual subtract.
// (RULE6) High product word plus accumulate operand.
// (RULE7) Accumulate operand minus high product word.
// (RULE8) Rounding adds 0x80000000 before high word.
// (RULE9) Plain high word of signed product.
// (RULE10) Condition flags kept on high word multiply.
// (RULE11) Dual halfword products summed to destination.
// (RULE12) Bottom product minus top product written.
// (RULE13) Product sum overflow sets sticky flag.
// (RULE14) Sign-extended halfword product added to pair.
// (RULE15) Sticky flag lives in status word.
// (RULE16) 32-bit results wrap, never saturate.
module dsmd_datapath (
    clk,
    srst,
    start,
    op,
    exchange,
    round_en,
    sel_top_first,
    sel_top_second,
    operand_first,
    operand_second,
    accumulate_operand,
    result_high_word_in,
    result_low_word_in,
    psw_in,
    psw_load,
    result_low_word,
    result_high_word,
    result_valid,
    result_long,
    program_status_word
);
    input wire clk;
    input wire srst;
    input wire start;
    input wire [`DSMD_OP_W-1:0] op;
    input wire exchange;
    input wire round_en;
    input wire sel_top_first;
    input wire sel_top_second;
    input wire [31:0] operand_first;
    input wire [31:0] operand_second;
    input wire [31:0] accumulate_operand;
    input wire [31:0] result_high_word_in;
    input wire [31:0] result_low_word_in;
    input wire [31:0] psw_in;
    input wire psw_load;
    output reg [31:0] result_low_word;
    output reg [31:0] result_high_word;
    output reg result_valid;
    output reg result_long;
    output reg [31:0] program_status_word;

    // ------------------------------------------------------------
    // Operand selection and products
    // ------------------------------------------------------------
    wire [31:0] second_sw;
    wire [31:0] prod_lo;
    wire [31:0] prod_hi;
    wire [31:0] prod_single;
    wire [15:0] single_a;
    wire [15:0] single_b;

    // (RULE2) Halfword exchange of second operand.
    assign second_sw = exchange ?
        {operand_second[`DSMD_HALF_LO], operand_second[`DSMD_HALF_HI]} : operand_second;

    // (RULE1) Two signed halfword products.
    dsmd_half_mul u_mul_lo (
        .a(operand_first[`DSMD_HALF_LO]),
        .b(second_sw[`DSMD_HALF_LO]),
        .p(prod_lo)
    );
    dsmd_half_mul u_mul_hi (
        .a(operand_first[`DSMD_HALF_HI]),
        .b(second_sw[`DSMD_HALF_HI]),
        .p(prod_hi)
    );

    assign single_a = sel_top_first ? operand_first[`DSMD_HALF_HI] : operand_first[`DSMD_HALF_LO];
    assign single_b = sel_top_second ? operand_second[`DSMD_HALF_HI] :
        operand_second[`DSMD_HALF_LO];
    dsmd_half_mul u_mul_single (
        .a(single_a),
        .b(single_b),
        .p(prod_single)
    );

    // ------------------------------------------------------------
    // Word multiply with optional rounding
    // ------------------------------------------------------------
    wire [63:0] word_prod;
    wire [63:0] word_rounded;
    wire [31:0] msw;

    assign word_prod = $signed(operand_first) * $signed(operand_second);
    // (RULE8) Rounding constant added before extraction.
    assign word_rounded = round_en ? word_prod + `DSMD_ROUND_CONST : word_prod;
    // (RULE9) Upper signed word of product.
    assign msw = word_rounded[63:32];

    // ------------------------------------------------------------
    // Result and overflow selection
    // ------------------------------------------------------------
    wire [32:0] diff_ext;
    wire [32:0] sum_ext;
    wire [63:0] pair_in;
    wire [63:0] diff64;
    wire [63:0] single64;
    // The product difference cannot overflow 33 bits, so it is formed wide.
    assign diff_ext = {prod_lo[31], prod_lo} - {prod_hi[31], prod_hi};
    assign sum_ext = {prod_lo[31], prod_lo} + {prod_hi[31], prod_hi};
    assign pair_in = {result_high_word_in, result_low_word_in};
    assign diff64 = {{31{diff_ext[32]}}, diff_ext};
    assign single64 = {{32{prod_single[31]}}, prod_single};

    reg [63:0] res_d;
    reg ovf_d;
    reg long_d;
    reg [33:0] acc_ext;

    always @* begin
        res_d = 64'h0000000000000000;
        ovf_d = 1'b0;
        long_d = 1'b0;
        acc_ext = 34'h000000000;
        case (op)
            `DSMD_OP_DUAL_MUL_SUB_ACC: begin
                // (RULE1) Difference plus accumulate, wrapped.
                acc_ext = {diff_ext[32], diff_ext} +
                    {{2{accumulate_operand[31]}}, accumulate_operand};
                res_d = {32'h00000000, acc_ext[31:0]};
                // (RULE4) Only the accumulate step can overflow.
                ovf_d = acc_ext[33:31] != {3{acc_ext[31]}};
            end
            `DSMD_OP_DUAL_MUL_SUB_ACC_LONG: begin
                // (RULE3) Difference added to 64-bit pair.
                res_d = pair_in + diff64;
                long_d = 1'b1;
            end
            `DSMD_OP_MSW_MUL_ACC: begin
                // (RULE6) High word plus accumulate.
                res_d = {32'h00000000, msw + accumulate_operand};
            end
            `DSMD_OP_MSW_MUL_SUB: begin
                // (RULE7) Accumulate minus high word.
                res_d = {32'h00000000, accumulate_operand - msw};
            end
            `DSMD_OP_MSW_MUL: begin
                // (RULE9) High word only.
                res_d = {32'h00000000, msw};
            end
            `DSMD_OP_DUAL_MUL_ADD: begin
                // (RULE11) Sum of both halfword products.
                // (RULE16) Sum wraps modulo two to the 32.
                res_d = {32'h00000000, sum_ext[31:0]};
                // (RULE13) Product sum overflow detect.
                ovf_d = sum_ext[32] != sum_ext[31];
            end
            `DSMD_OP_DUAL_MUL_DIFF: begin
                // (RULE12) Bottom minus top product.
                res_d = {32'h00000000, diff_ext[31:0]};
            end
            `DSMD_OP_LONG_HALFWORD_MUL_ACC: begin
                // (RULE14) Sign-extended product added.
                res_d = pair_in + single64;
                long_d = 1'b1;
            end
            default: begin
                res_d = 64'h0000000000000000;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registered results and status word
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (srst) begin
            result_low_word <= 32'h00000000;
            result_high_word <= 32'h00000000;
            result_valid <= 1'b0;
            result_long <= 1'b0;
            program_status_word <= `DSMD_PSW_RESET;
        end else begin
            result_valid <= start;
            if (start) begin
                result_low_word <= res_d[31:0];
                result_high_word <= res_d[63:32];
                result_long <= long_d;
            end
            // (RULE15) Sticky flag set wins over a load; other bits untouched.
            // (RULE5) N, Z, C, V never changed by execution.
            // (RULE10) Word multiply leaves flags alone.
            if (psw_load) begin
                program_status_word <= psw_in;
                if (start && ovf_d) begin
                    program_status_word[`DSMD_PSW_Q] <= 1'b1;
                end
            end else if (start && ovf_d) begin
                program_status_word[`DSMD_PSW_Q] <= 1'b1;
            end
        end
    end
endmodule

// [bench/dsmd_asserts.sv]
// Concurrent checks on the ports of the signed multiply datapath.
`timescale 1ns/1ps
module dsmd_asserts (
    input wire clk,
    input wire srst,
    input wire start,
    input wire [2:0] op,
    input wire round_en,
    input wire [31:0] operand_first,
    input wire [31:0] operand_second,
    input wire psw_load,
    input wire [31:0] result_low_word,
    input wire [31:0] result_high_word,
    input wire result_valid,
    input wire result_long,
    input wire [31:0] program_status_word
);
    wire signed [63:0] prod = $signed(operand_first) * $signed(operand_second);
    wire [63:0] rnd = prod + {round_en, 31'h0};
    wire [31:0] msw = rnd[63:32];
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    AST_VALID_ONE: assert property (start |=> result_valid)
        else $error("result valid missing after start");
    AST_VALID_ONLY: assert property (!start |=> !result_valid)
        else $error("result valid without start");
    AST_LONG_FLAG: assert property (start |=>
        result_long == ($past(op) == 3'h1 || $past(op) == 3'h7))
        else $error("long flag wrong for operation");
    AST_HIGH_ZERO: assert property (result_valid && !result_long |->
        result_high_word == 32'h0)
        else $error("high word not zero for short result");
    AST_FLAGS_KEPT: assert property (!psw_load |=> $stable(program_status_word[31:28]))
        else $error("condition flags changed");
    AST_LOW_KEPT: assert property (!psw_load |=> $stable(program_status_word[26:0]))
        else $error("other status bits changed");
    AST_Q_STICKY: assert property (program_status_word[27] && !psw_load |=>
        program_status_word[27])
        else $error("sticky flag cleared");
    AST_Q_SOURCE: assert property (!psw_load && !program_status_word[27] &&
        !(start && (op == 3'h0 || op == 3'h5)) |=> !program_status_word[27])
        else $error("sticky flag set without source");
    AST_MSW: assert property (start && op == 3'h4 |=> result_low_word == $past(msw))
        else $error("high word product wrong");
endmodule
bind dsmd_datapath dsmd_asserts chk_i (.clk, .srst, .start, .op, .round_en, .operand_first,
    .operand_second, .psw_load, .result_low_word, .result_high_word, .result_valid,
    .result_long, .program_status_word);

// [bench/tb_top.sv]
// Self-checking testbench for the signed multiply datapath.
`timescale 1ns/1ps
module tb_top;
    reg clk, srst, start, exchange, round_en, sel_top_first, sel_top_second, psw_load;
    reg [2:0] op;
    reg [31:0] operand_first, operand_second, accumulate_operand, psw_in;
    reg [31:0] result_high_word_in, result_low_word_in, p_m;
    wire [31:0] result_low_word, result_high_word, program_status_word;
    wire result_valid, result_long;
    integer error_cnt, num_checks, i;
    dsmd_datapath uut (.clk, .srst, .start, .op, .exchange, .round_en, .sel_top_first,
        .sel_top_second, .operand_first, .operand_second, .accumulate_operand,
        .result_high_word_in, .result_low_word_in, .psw_in, .psw_load, .result_low_word,
        .result_high_word, .result_valid, .result_long, .program_status_word);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task chk(input string name, input [63:0] exp, input [63:0] got);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    function signed [63:0] hp(input [15:0] a, input [15:0] b);
        hp = $signed(a) * $signed(b);
    endfunction
    // Reference result of one operation; bit 64 flags an accumulate (op 0) or product sum (op 5) overflow.
    function [64:0] calc(input [2:0] o, input x, input r, input [1:0] s, input [31:0] a,
        input [31:0] b, input [31:0] c, input [63:0] pr);
        reg [31:0] bs;
        reg signed [63:0] lo, hi, m, t;
        begin
            bs = x ? {b[15:0], b[31:16]} : b;
            lo = hp(a[15:0], bs[15:0]);
            hi = hp(a[31:16], bs[31:16]);
            m = ($signed(a) * $signed(b) + (r ? 64'sh80000000 : 64'sh0)) >>> 32;
            case (o)
                3'h0: t = lo - hi + $signed(c);
                3'h1: t = lo - hi + $signed(pr);
                3'h2: t = m + $signed(c);
                3'h3: t = $signed(c) - m;
                3'h4: t = m;
                3'h5: t = lo + hi;
                3'h6: t = lo - hi;
                default: t = hp(s[1] ? a[31:16] : a[15:0], s[0] ? b[31:16] : b[15:0]) +
                    $signed(pr);
            endcase
            calc[63:0] = (o == 3'h1 || o == 3'h7) ? t : {32'h0, t[31:0]};
            calc[64] = (o == 3'h0 || o == 3'h5) && (t[63:31] != {33{t[31]}});
        end
    endfunction
    task run(input [2:0] o, input x, input r, input [1:0] s, input [31:0] a, input [31:0] b,
        input [31:0] c, input [63:0] pr);
        reg [64:0] e;
        begin
            e = calc(o, x, r, s, a, b, c, pr);
            p_m[27] = p_m[27] | e[64];
            start <= 1'b1;
            {op, exchange, round_en, sel_top_first, sel_top_second} <= {o, x, r, s};
            {operand_first, operand_second, accumulate_operand} <= {a, b, c};
            {result_high_word_in, result_low_word_in} <= pr;
            @(posedge clk);
            start <= 1'b0;
            #1;
            chk("valid", 64'h1, result_valid);
            chk("result", e[63:0], {result_high_word, result_low_word});
            chk("long", o == 3'h1 || o == 3'h7, result_long);
            chk("psw", p_m, program_status_word);
            @(posedge clk);
        end
    endtask
    task load(input [31:0] v);
        begin
            psw_load <= 1'b1;
            psw_in <= v;
            @(posedge clk);
            psw_load <= 1'b0;
            p_m = v;
            #1;
            chk("psw load", v, program_status_word);
            @(posedge clk);
        end
    endtask
    task t_long;
        for (i = 0; i < 8; i = i + 1)
            run(i < 4 ? 3'h1 : 3'h7, i[0], 1'b0, i[1:0], 32'h7fff_8000 ^ i, 32'h8001_7fff,
                32'h0, i[1] ? 64'h0000_0000_ffff_fffe : 64'hffff_ffff_0000_0005);
    endtask
    task t_msw;
        for (i = 0; i < 6; i = i + 1)
            run(3'h2 + i[2:1], 1'b0, i[0], 2'h0, 32'h0001_0000 - i[2:1] * 32'h2345_6789,
                32'h8000 + i[2:1], 32'h7fff_ffff, 64'h0);
    endtask
    task t_dual;
        for (i = 0; i < 12; i = i + 1)
            run(i % 3 == 0 ? 3'h0 : 3'(4 + i % 3), i[2], 1'b0, 2'h0,
                32'h7ffe_8001 + i * 32'h0931_2467, 32'h8000_7fff - i * 32'h1203_0451,
                i * 32'h0111_1111, 64'h0);
    endtask
    task t_psw;
        begin
            load(32'hf000_0000);
            run(3'h5, 1'b0, 1'b0, 2'h0, 32'h8000_8000, 32'h8000_8000, 32'h0, 64'h0);
            run(3'h4, 1'b0, 1'b1, 2'h0, 32'h8000_8000, 32'h8000_8000, 32'h0, 64'h0);
            load(32'h0000_0000);
            run(3'h1, 1'b0, 1'b0, 2'h0, 32'h0001_0002, 32'h0001_0003, 32'h0,
                64'h7fff_ffff);
            run(3'h0, 1'b0, 1'b0, 2'h0, 32'h0001_0002, 32'h0001_0003, 32'h7fff_ffff,
                64'h0);
        end
    endtask
    // A status load and a sticky set in one cycle: the load lands and the set wins.
    task t_clash;
        begin
            psw_load <= 1'b1;
            psw_in <= 32'h5000_0000;
            start <= 1'b1;
            {op, exchange} <= {3'h5, 1'b0};
            {operand_first, operand_second} <= {32'h8000_8000, 32'h8000_8000};
            @(posedge clk);
            psw_load <= 1'b0;
            start <= 1'b0;
            #1;
            chk("psw clash", 64'h0000_0000_5800_0000, program_status_word);
            chk("clash result", 64'h0000_0000_8000_0000, {result_high_word, result_low_word});
            p_m = 32'h5800_0000;
            @(posedge clk);
        end
    endtask
    task report_and_stop;
        begin
            $display("errors %0d checks %0d", error_cnt, num_checks);
            if (error_cnt == 0 && num_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    initial begin
        {srst, start, exchange, round_en, sel_top_first, sel_top_second, psw_load} = 7'h40;
        {op, operand_first, operand_second, accumulate_operand, psw_in} = 0;
        {result_high_word_in, result_low_word_in, p_m} = 0;
        error_cnt = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        #1;
        chk("reset words", 64'h0, {result_high_word, result_low_word});
        chk("reset flags", 64'h0, {result_valid, result_long, program_status_word});
        @(posedge clk);
        srst <= 1'b0;
        t_long;
        t_msw;
        t_dual;
        t_psw;
        t_clash;
        report_and_stop;
    end
endmodule
